// ===== ocd_pkg.sv
// Package for the ON-state overcurrent diagnostic block: codes, timings, carriers.
// Assumes a 100 MHz system clock; analog comparator and gate drivers live outside.
package ocd_pkg;
   // ****************************************
   // Diagnostic codes
   // ****************************************
   localparam logic [2:0] CODE_OC_PIN = 3'h0;
   localparam logic [2:0] CODE_OC = 3'h1;
   localparam logic [2:0] CODE_NO_FAIL = 3'h4;
   localparam logic [2:0] CODE_NO_OC = 3'h5;
   localparam logic [2:0] CODE_NO_DIAG = 3'h7;
   // Gate current settings
   localparam logic [1:0] GCS_1MA = 2'h0;
   localparam logic [1:0] GCS_5MA = 2'h1;
   localparam logic [1:0] GCS_20MA = 2'h3;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int DEGLITCH_MIN_NS = 600;
   localparam int DETECT_MIN_NS = 2000;
   localparam logic [7:0] DEGLITCH_CYC = 8'((DEGLITCH_MIN_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] DETECT_CYC = 8'((DETECT_MIN_NS * CLK_MHZ + 999) / 1000);
   // Whole filter is wider than eight bits, so the sum is kept at nine
   localparam logic [8:0] FILTER_CYC = 9'(DEGLITCH_CYC) + 9'(DETECT_CYC);
   // Blanking typical times in 100 ns units, index by blanking_time_setting
   localparam int BLANK_TENTH_US [8] = '{111, 156, 200, 311, 422, 533, 978, 1422};
   localparam logic [8:0] RST_CNT = 9'h000;
   localparam logic [14:0] RST_BLANK = 15'h0000;
   typedef struct packed {
      logic [2:0] code;
      logic oc_latched;    // output held off after overcurrent
      logic read_seen;     // readout since the overcurrent
      logic boost;         // raised shut-off current active
      logic ctrl_prev;
      logic on_prev;
      logic blanking;
      logic [14:0] blank_cnt;
      logic filt_on;
      logic [8:0] filt_cnt;
      logic off_ok;        // OFF-state no-fault latch seen
      logic first_on;      // report 100 once
   } ocd_chan_type;
   typedef struct packed {
      logic src_sel;       // 1 selects serial_on_command_bit
      logic serial_on;
      logic sense_shunt;
      logic reengage_policy;
      logic [1:0] gate_current;
      logic peak_hold;
      logic hbridge;
      logic [2:0] blank_setting;
   } ocd_cfg_type;
endpackage : ocd_pkg

// ===== ocd_overcurrent.sv
// Eight-channel ON-state overcurrent protection and diagnostic encoder.
// Assumes comparator and pins are asynchronous (double synchronised here);
// config and readout strobe come from the SPI logic on the same clock.
// Behaviour
// R1: Events during readout reported next request
// R2: Normal ON state reports code 101
// R3: Code 100 once after OFF to ON
// R4: Overcurrent shuts output, records 001/000
// R5: Low gate currents boosted on overcurrent
// R6: Boost on detection, revert after readout
// R7: Output off until selected re-engage condition
// R8: H-bridge always needs readout before re-engage
// R9: Control from pin or serial bit
// R10: Sense bit selects drain-source or shunt
// R11: Shunt crossing stops blanking, starts filter
// R12: Peak-hold overcurrent in blanking reports 000
// R13: Drain-source compares after blanking expires
// R14: Drain-source crossing in blanking engages filter
// R15: Host programs six-bit threshold per channel
// R16: Highest-priority event encoded only
// R17: Readout or reset clears latches, filters
// R18: Blanking gates only the no-overcurrent code
// R19: Deglitch then detection filter before declaring
// R20: Independent state for each channel
`timescale 1ns/100ps
`default_nettype none
module ocd_overcurrent #(
   parameter int N_CH = 8
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire ocd_pkg::ocd_cfg_type cfg_i [N_CH],
   input wire logic [5:0] overcurrent_threshold_code_i [N_CH],
   input wire logic shutoff_current_boost_select_i,
   input wire logic [N_CH-1:0] channel_control_pin_i,
   input wire logic [N_CH-1:0] comparator_over_i,
   input wire logic [N_CH-1:0] off_no_fault_i,
   input wire logic diag_read_i,
   output logic [N_CH-1:0] gate_on_o,
   output logic [1:0] gate_current_o [N_CH],
   output logic [5:0] threshold_o [N_CH],
   output logic [2:0] channel_fault_code_o [N_CH]
);
   // ****************************************
   // Helpers
   // ****************************************
   // Blanking length in cycles: tenths of microseconds times ten cycles
   function automatic logic [14:0] blank_cycles(input logic [2:0] sel);
      blank_cycles = 15'(ocd_pkg::BLANK_TENTH_US[sel] * (ocd_pkg::CLK_MHZ / 10));
   endfunction : blank_cycles

   // Raised shut-off current for a given normal setting
   function automatic logic [1:0] boosted(input logic [1:0] g, input logic sel);
      if (g == ocd_pkg::GCS_1MA) begin
         boosted = sel ? ocd_pkg::GCS_20MA : ocd_pkg::GCS_5MA;
      end else if (g == ocd_pkg::GCS_5MA) begin
         boosted = ocd_pkg::GCS_20MA;
      end else begin
         boosted = g;
      end
   endfunction : boosted

   // ****************************************
   // Synchronisers
   // ****************************************
   logic [N_CH-1:0] pin_s1_reg, pin_s2_reg, cmp_s1_reg, cmp_s2_reg, cmp_prev_reg;
   logic [N_CH-1:0] okf_s1_reg, okf_s2_reg;
   // Two stages each; edge detect reads only the second stage
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         cmp_s1_reg <= '0;
         cmp_s2_reg <= '0;
         cmp_prev_reg <= '0;
         okf_s1_reg <= '0;
         okf_s2_reg <= '0;
      end else begin
         pin_s1_reg <= channel_control_pin_i;
         pin_s2_reg <= pin_s1_reg;
         cmp_s1_reg <= comparator_over_i;
         cmp_s2_reg <= cmp_s1_reg;
         cmp_prev_reg <= cmp_s2_reg;
         okf_s1_reg <= off_no_fault_i;
         okf_s2_reg <= okf_s1_reg;
      end
   end

   // ****************************************
   // Channel state
   // ****************************************
   ocd_pkg::ocd_chan_type ch_reg [N_CH];
   ocd_pkg::ocd_chan_type ch_next [N_CH];
   logic [N_CH-1:0] oc_det;

   // Per-channel next state; one copy per channel keeps channels independent
   always_comb begin
      for (int i = 0; i < N_CH; i++) begin
         logic ctrl, on_now, rise, over, switch_ev, need_read, deg_done;
         ch_next[i] = ch_reg[i]; // see R20
         deg_done = 1'b0;
         ctrl = cfg_i[i].src_sel ? cfg_i[i].serial_on : pin_s2_reg[i]; // see R9
         rise = cmp_s2_reg[i] && !cmp_prev_reg[i];
         over = cmp_s2_reg[i];
         switch_ev = ctrl && !ch_reg[i].ctrl_prev;
         need_read = cfg_i[i].hbridge || cfg_i[i].reengage_policy; // see R8
         ch_next[i].ctrl_prev = ctrl;
         oc_det[i] = 1'b0;
         // Readout clears latches and restarts filters; events below still win
         if (diag_read_i) begin // see R17
            ch_next[i].code = ocd_pkg::CODE_NO_DIAG;
            ch_next[i].boost = 1'b0; // see R6
            ch_next[i].filt_on = 1'b0;
            ch_next[i].filt_cnt = ocd_pkg::RST_CNT;
            ch_next[i].first_on = 1'b0;
            if (ch_reg[i].oc_latched) begin
               ch_next[i].read_seen = 1'b1;
            end
         end
         // Re-engagement after overcurrent
         if (ch_reg[i].oc_latched && switch_ev &&
             (!need_read || ch_reg[i].read_seen)) begin // see R7
            ch_next[i].oc_latched = 1'b0;
            ch_next[i].read_seen = 1'b0;
         end
         on_now = ctrl && !ch_next[i].oc_latched;
         ch_next[i].on_prev = on_now;
         if (!ctrl) begin
            ch_next[i].off_ok = okf_s2_reg[i] || ch_reg[i].off_ok;
         end
         // OFF to ON starts blanking
         if (on_now && !ch_reg[i].on_prev) begin
            ch_next[i].blanking = 1'b1;
            ch_next[i].blank_cnt = ocd_pkg::RST_BLANK;
            ch_next[i].first_on = ch_reg[i].off_ok; // see R3
            ch_next[i].off_ok = 1'b0;
            ch_next[i].filt_on = 1'b0;
            ch_next[i].filt_cnt = ocd_pkg::RST_CNT;
         end else if (on_now) begin
            // Rising crossing stops blanking and engages filter in both modes
            if (rise && !ch_reg[i].filt_on) begin // see R11 see R14
               ch_next[i].blanking = 1'b0;
               ch_next[i].filt_on = 1'b1;
               ch_next[i].filt_cnt = ocd_pkg::RST_CNT;
            end else if (ch_reg[i].blanking) begin
               ch_next[i].blank_cnt = ch_reg[i].blank_cnt + 15'h0001;
               if (ch_reg[i].blank_cnt + 15'h0001 >= blank_cycles(cfg_i[i].blank_setting)) begin
                  ch_next[i].blanking = 1'b0;
                  // Blanking gates only the good code, never the fault
                  if (ch_reg[i].code[2]) begin // see R18 see R2 see R16
                     ch_next[i].code = ch_reg[i].first_on ? ocd_pkg::CODE_NO_FAIL
                                                          : ocd_pkg::CODE_NO_OC;
                  end
                  // Drain-source: level compare once blanking has expired
                  if (!cfg_i[i].sense_shunt && over) begin // see R10 see R13
                     ch_next[i].filt_on = 1'b1;
                     ch_next[i].filt_cnt = ocd_pkg::RST_CNT;
                  end
               end
            end else if (over && !ch_reg[i].filt_on && !cfg_i[i].sense_shunt) begin
               ch_next[i].filt_on = 1'b1; // see R13
               ch_next[i].filt_cnt = ocd_pkg::RST_CNT;
            end
            // Deglitch then detection; a drop below threshold restarts
            if (ch_reg[i].filt_on) begin
               deg_done = ch_reg[i].filt_cnt >= ocd_pkg::FILTER_CYC - 9'h001;
               if (!over) begin
                  ch_next[i].filt_on = 1'b0;
               end else if (deg_done) begin // see R19
                  oc_det[i] = 1'b1;
                  ch_next[i].filt_on = 1'b0;
                  ch_next[i].oc_latched = 1'b1; // see R4
                  // Gate drops with the latch, one cycle after detection, not two
                  ch_next[i].on_prev = 1'b0; // see R4
                  ch_next[i].read_seen = 1'b0;
                  ch_next[i].boost = 1'b1; // see R6
                  ch_next[i].first_on = 1'b0;
                  // Event beats a same-cycle readout clear
                  if (cfg_i[i].peak_hold && ch_reg[i].blank_cnt <
                      blank_cycles(cfg_i[i].blank_setting)) begin // see R12
                     ch_next[i].code = ocd_pkg::CODE_OC_PIN;
                  end else if (ch_next[i].code != ocd_pkg::CODE_OC_PIN) begin // see R16 see R1
                     ch_next[i].code = ocd_pkg::CODE_OC;
                  end
               end else begin
                  ch_next[i].filt_cnt = ch_reg[i].filt_cnt + 9'h001;
               end
            end
         end else begin
            ch_next[i].blanking = 1'b0;
            ch_next[i].filt_on = 1'b0;
         end
      end
   end

   // Register all channel state
   always_ff @(posedge sys_clk_i) begin
      for (int i = 0; i < N_CH; i++) begin
         if (!nrst_i) begin // see R17
            ch_reg[i] <= '{code: ocd_pkg::CODE_NO_DIAG, blank_cnt: ocd_pkg::RST_BLANK,
                           filt_cnt: ocd_pkg::RST_CNT, default: 1'b0};
         end else begin
            ch_reg[i] <= ch_next[i];
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Threshold passes through; host owns the six-bit code per channel
   always_comb begin
      for (int i = 0; i < N_CH; i++) begin
         gate_on_o[i] = ch_reg[i].on_prev;
         gate_current_o[i] = ch_reg[i].boost ?
            boosted(cfg_i[i].gate_current, shutoff_current_boost_select_i)
            : cfg_i[i].gate_current; // see R5
         threshold_o[i] = overcurrent_threshold_code_i[i]; // see R15
         channel_fault_code_o[i] = ch_reg[i].code;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_oc_off;
      @(posedge sys_clk_i) disable iff (!nrst_i)
         oc_det[0] |=> !gate_on_o[0];
   endproperty
   a_oc_off: assert property (p_oc_off) else $error("output on after overcurrent"); // see R4

   property p_oc_code;
      @(posedge sys_clk_i) disable iff (!nrst_i)
         oc_det[0] |=> !channel_fault_code_o[0][2];
   endproperty
   a_oc_code: assert property (p_oc_code) else $error("fault code not set"); // see R16

   property p_boost;
      @(posedge sys_clk_i) disable iff (!nrst_i)
         (oc_det[0] && cfg_i[0].gate_current == ocd_pkg::GCS_5MA)
         |=> gate_current_o[0] == ocd_pkg::GCS_20MA;
   endproperty
   a_boost: assert property (p_boost) else $error("shut-off current not raised"); // see R5

   property p_revert;
      @(posedge sys_clk_i) disable iff (!nrst_i)
         (diag_read_i && !oc_det[0]) |=> gate_current_o[0] == $past(cfg_i[0].gate_current);
   endproperty
   a_revert: assert property (p_revert) else $error("gate current not restored"); // see R6

   property p_hold_off;
      @(posedge sys_clk_i) disable iff (!nrst_i)
         (ch_reg[0].oc_latched && !diag_read_i) ##1 ch_reg[0].oc_latched |-> !gate_on_o[0];
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("output re-engaged early"); // see R7

   property p_hb;
      @(posedge sys_clk_i) disable iff (!nrst_i)
         (cfg_i[0].hbridge && ch_reg[0].oc_latched && !ch_reg[0].read_seen && !diag_read_i)
         |=> ch_reg[0].oc_latched;
   endproperty
   a_hb: assert property (p_hb) else $error("H-bridge re-engaged without readout"); // see R8

   property p_read_clear;
      @(posedge sys_clk_i) disable iff (!nrst_i)
         (diag_read_i && !oc_det[0] && !ch_reg[0].blanking) |=>
         channel_fault_code_o[0] == ocd_pkg::CODE_NO_DIAG;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("latch not cleared"); // see R17

   property p_event_wins;
      @(posedge sys_clk_i) disable iff (!nrst_i)
         (diag_read_i && oc_det[0]) |=> !channel_fault_code_o[0][2];
   endproperty
   a_event_wins: assert property (p_event_wins) else $error("event lost in readout"); // see R1

   property p_filter;
      @(posedge sys_clk_i) disable iff (!nrst_i)
         oc_det[0] |-> $past(cmp_s2_reg[0], 3) && $past(ch_reg[0].filt_on, 3);
   endproperty
   a_filter: assert property (p_filter) else $error("overcurrent without filter"); // see R19
endmodule : ocd_overcurrent
`default_nettype wire

// ===== ocd_host_model.sv
// Host-side model: issues readout pulses and programs per-channel thresholds.
// Assumes the host shares the system clock with the diagnostic block.
`timescale 1ns/100ps
`default_nettype none
module ocd_host_model #(
   parameter int N_CH = 8
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic read_req_i,
   input wire logic thr_wr_i,
   input wire logic [2:0] thr_ch_i,
   input wire logic [5:0] thr_code_i,
   output logic diag_read_o,
   output logic [5:0] thr_code_o [N_CH]
);
   logic req_prev_reg;
   // One-cycle readout pulse per request edge, so a held request reads once
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         req_prev_reg <= 1'b0;
         diag_read_o <= 1'b0;
      end else begin
         req_prev_reg <= read_req_i;
         diag_read_o <= read_req_i & ~req_prev_reg;
      end
   end
   // Six-bit code per channel, one channel per write
   always_ff @(posedge sys_clk_i) begin
      if (thr_wr_i) begin
         thr_code_o[thr_ch_i] <= thr_code_i;
      end
   end
endmodule : ocd_host_model
`default_nettype wire

// ===== tb_ocd_overcurrent.sv
// Self-checking bench for the overcurrent diagnostic block, random channels.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_ocd_overcurrent;
   localparam int N_CH = 8;
   logic sys_clk_i;
   logic nrst_i;
   ocd_pkg::ocd_cfg_type cfg [N_CH];
   logic [5:0] thr_code [N_CH];
   logic [5:0] exp_thr [N_CH];
   logic [5:0] thr_out [N_CH];
   logic [5:0] thr_prog;
   logic [2:0] thr_ch;
   logic thr_wr;
   logic boost_sel;
   logic read_req;
   logic diag_read;
   logic [N_CH-1:0] pin;
   logic [N_CH-1:0] comp;
   logic [N_CH-1:0] off_ok;
   logic [N_CH-1:0] gate_on;
   logic [1:0] gate_cur [N_CH];
   logic [2:0] code [N_CH];
   int n_mismatch;
   int n_compared;
   ocd_host_model #(.N_CH(N_CH)) i_ocd_host_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .read_req_i(read_req), .thr_wr_i(thr_wr), .thr_ch_i(thr_ch), .thr_code_i(thr_prog),
      .diag_read_o(diag_read), .thr_code_o(thr_code));
   ocd_overcurrent #(.N_CH(N_CH)) i_ocd_overcurrent (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .cfg_i(cfg), .overcurrent_threshold_code_i(thr_code),
      .shutoff_current_boost_select_i(boost_sel), .channel_control_pin_i(pin),
      .comparator_over_i(comp), .off_no_fault_i(off_ok), .diag_read_i(diag_read),
      .gate_on_o(gate_on), .gate_current_o(gate_cur), .threshold_o(thr_out),
      .channel_fault_code_o(code));
   // ****************************************
   // Clock and helpers
   // ****************************************
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // Inputs always move 1 ns after the edge to avoid races
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : tick
   task automatic compare(input logic [5:0] got, input logic [5:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : compare
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   // Bounded wait for a code; running out ends the run
   task automatic wait_code(input int ch, input logic [2:0] exp, input int bound);
      int k;
      for (k = 0; k < bound && code[ch] !== exp; k++) tick(1);
      compare(6'(code[ch]), 6'(exp));
      if (code[ch] !== exp) complete_run();
   endtask : wait_code
   task automatic do_read();
      read_req = 1'b1;
      tick(1);
      read_req = 1'b0;
      tick(3);
   endtask : do_read
   task automatic toggle(input int ch);
      pin[ch] = 1'b0;
      tick(5);
      pin[ch] = 1'b1;
      tick(5);
   endtask : toggle
   function automatic logic [1:0] exp_boost(input logic [1:0] gcs, input logic sel);
      if (gcs == ocd_pkg::GCS_1MA) return sel ? ocd_pkg::GCS_20MA : ocd_pkg::GCS_5MA;
      if (gcs == ocd_pkg::GCS_5MA) return ocd_pkg::GCS_20MA;
      return gcs;
   endfunction : exp_boost
   // One overcurrent episode; a short glitch first must not trip after blanking
   task automatic trip(input int ch, input logic in_blank, input logic [2:0] exp_code);
      pin[ch] = 1'b1;
      if (in_blank) begin
         tick(20);
      end else begin
         tick(900);
         compare(6'(code[ch] == ocd_pkg::CODE_NO_OC), 6'h0);
         wait_code(ch, ocd_pkg::CODE_NO_OC, 400);
         comp[ch] = 1'b1;
         tick(20 + $urandom % 200);
         comp[ch] = 1'b0;
         tick(5);
         compare(6'(gate_on[ch]), 6'h1);
      end
      comp[ch] = 1'b1;
      tick(250);
      compare(6'(gate_on[ch]), 6'h1);
      wait_code(ch, exp_code, 200);
      compare(6'(gate_on[ch]), 6'h0);
      compare(6'(gate_cur[ch]), 6'(exp_boost(cfg[ch].gate_current, boost_sel)));
      comp[ch] = 1'b0;
   endtask : trip
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int ch;
      int c2;
      logic need;
      void'($urandom(32'ha044db6b));
      nrst_i = 1'b0;
      for (int i = 0; i < N_CH; i++) cfg[i] = '0;
      {pin, comp, off_ok, read_req, thr_wr, thr_ch, thr_prog, boost_sel} = '0;
      tick(4);
      nrst_i = 1'b1;
      for (int i = 0; i < N_CH; i++) begin
         compare(6'(code[i]), 6'(ocd_pkg::CODE_NO_DIAG));
         compare(6'(gate_on[i]), 6'h0);
         thr_ch = 3'(i);
         thr_prog = 6'($urandom);
         exp_thr[i] = thr_prog;
         thr_wr = 1'b1;
         tick(1);
      end
      thr_wr = 1'b0;
      tick(1);
      for (int i = 0; i < N_CH; i++) compare(thr_out[i], exp_thr[i]);
      // Serial-controlled channel with OFF-state no-fault seen stays on all run
      // Channel 0 is kept free so the in-design checks see a trip
      c2 = 1 + $urandom % (N_CH - 1);
      cfg[c2].src_sel = 1'b1;
      off_ok[c2] = 1'b1;
      tick(4);
      cfg[c2].serial_on = 1'b1;
      tick(2);
      compare(6'(gate_on[c2]), 6'h1);
      wait_code(c2, ocd_pkg::CODE_NO_FAIL, 1300);
      // Policy and H-bridge combinations with both boost steps
      for (int m = 0; m < 4; m++) begin
         ch = (m == 2) ? 0 : (c2 + 1 + $urandom % 7) % N_CH;
         cfg[ch] = '0;
         cfg[ch].reengage_policy = m[0];
         cfg[ch].hbridge = m[1];
         cfg[ch].sense_shunt = 1'($urandom);
         cfg[ch].gate_current = m[1] ? ocd_pkg::GCS_5MA : ocd_pkg::GCS_1MA;
         boost_sel = m[0] ^ m[1];
         need = m[0] | m[1];
         trip(ch, 1'b0, ocd_pkg::CODE_OC);
         toggle(ch);
         compare(6'(gate_on[ch]), 6'(!need));
         do_read();
         compare(6'(gate_cur[ch]), 6'(cfg[ch].gate_current));
         if (need) compare(6'(code[ch]), 6'(ocd_pkg::CODE_NO_DIAG));
         toggle(ch);
         compare(6'(gate_on[ch]), 6'h1);
         pin[ch] = 1'b0;
         tick(5);
         do_read();
      end
      // Peak-and-hold overcurrent inside long blanking, both sensing methods
      for (int k = 0; k < 2; k++) begin
         ch = (c2 + 1 + $urandom % 7) % N_CH;
         cfg[ch] = '0;
         cfg[ch].peak_hold = 1'b1;
         cfg[ch].sense_shunt = k[0];
         cfg[ch].blank_setting = 3'h7;
         trip(ch, 1'b1, ocd_pkg::CODE_OC_PIN);
         pin[ch] = 1'b0;
         tick(5);
         do_read();
      end
      compare(6'(gate_on[c2]), 6'h1);
      complete_run();
   end
endmodule : tb_ocd_overcurrent
`default_nettype wire
